/* hw/ascii_cmd_parser.sv */
// ascii command interpreter for an eight-channel analog input module
// Overview of operation
// R1: '#'+address+CR reads all channels, answered '>' plus every value and CR.
// R2: disabled channels read back as spaces in the all-channel reply.
// R3: syntax, checksum or address errors produce no reply at all.
// R4: addressed but unexecutable commands reply '?', own address, CR.
// R5: '#'+address+digit reads one channel; disabled channel gets the '?' reply.
// R6: format byte bits 1:0 pick engineering, percent or hex two's complement.
// R7: format byte bit 6 enables two checksum characters on commands and replies.
// R8: host writes bit 7 zero and bits 5..2 zero.
// R9: '%' config carries address, new address, type, baud, format; stored nonvolatile.
// R10: baud codes 01..08 map to 300 up to 38400 bits per second.
// R11: reconfiguration only in strap default state at address 00, else '?'.
// R12: configuration acknowledged with '!', new address, CR.
// R13: '$'+address+'2' returns '!', address, type, baud, format, CR.
// R14: '$'+address+'1'+digit trims the zero offset of that channel.
// R15: address is two hex characters covering 00 to FF.
// R16: accepted configuration-type replies start with '!'.
// R17: checksum is byte sum of preceding characters, as two hex characters.
// R18: host sends upper-case command letters only.
// R19: strap pin low at power-up selects the default state.
// R20: characters buffer until CR; overflowed partial commands are dropped silently.
// R21: no reply starts before the terminated command is validated.
`timescale 1ns/10ps
`include "ascii_cmd_defs.svh"
`default_nettype none
module ascii_cmd_parser
    import ascii_cmd_pkg::*;
#(
    parameter int BUF_DEPTH = 16,
    parameter int CH_WIDTH = 16
) (
    input wire logic MCLK,
    input wire logic ARST_N,
    input wire logic CONFIG_N,
    input wire logic [7:0] RX_DATA,
    input wire logic RX_VALID,
    output logic [7:0] TX_DATA,
    output logic TX_VALID,
    input wire logic TX_READY,
    input wire logic [8*CH_WIDTH-1:0] CH_VALUE,
    input wire logic [7:0] CH_ENABLE,
    output logic [1:0] FORMAT_SEL,
    output logic [15:0] BAUD_BPS,
    output logic DEFAULT_STATE,
    output logic NV_WRITE,
    output cfg_type NV_DATA,
    output logic CAL_START,
    output logic [2:0] CAL_CHANNEL
);
    localparam int REP_DEPTH = 41;

    function automatic logic [4:0] hexv(input logic [7:0] c);
        // upper case only: lower-case letters count as syntax errors
        if (c >= `CHR_ZERO && c <= `CHR_NINE) begin
            return {1'b1, c[3:0]};
        end
        if (c >= `CHR_UA && c <= `CHR_UF) begin
            return {1'b1, 4'(c[3:0] + 4'h9)};
        end
        return 5'h00;
    endfunction

    function automatic logic [7:0] hexc(input logic [3:0] n);
        return (n < 4'ha) ? 8'(`CHR_ZERO + n) : 8'(`CHR_UA + n - 4'ha);
    endfunction

    // ***************************************
    // strap synchroniser
    // ***************************************
    logic [1:0] sync_q, sync_d;
    always_comb begin
        sync_d = {sync_q[0], CONFIG_N};
    end
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            sync_q <= 2'h3;
        end else begin
            sync_q <= sync_d;
        end
    end

    // ***************************************
    // per-channel value text
    // ***************************************
    logic [39:0] ch_txt [8];
    logic [2:0] ch_len;
    state_type state_q, state_d;
    cfg_type cfg_q, cfg_d;
    assign ch_len = (cfg_q.format_checksum_byte[`FMT_SEL_MSB:0] == `FMT_HEX) ? 3'd4 : 3'd5;
    for (genvar g = 0; g < 8; g++) begin : g_ch
        logic [CH_WIDTH-1:0] v, m;
        assign v = CH_VALUE[g*CH_WIDTH +: CH_WIDTH];
        assign m = v[CH_WIDTH-1] ? CH_WIDTH'(-v) : v;
        // hex mode sends raw two's complement, the others sign and magnitude [R6]
        assign ch_txt[g] = (ch_len == 3'd4)
            ? {hexc(v[15:12]), hexc(v[11:8]), hexc(v[7:4]), hexc(v[3:0]), 8'h00}
            : {v[CH_WIDTH-1] ? `CHR_MINUS : `CHR_PLUS,
               hexc(m[15:12]), hexc(m[11:8]), hexc(m[7:4]), hexc(m[3:0])};
    end

    // ***************************************
    // command decode
    // ***************************************
    logic [7:0] buf_q [BUF_DEPTH];
    logic [7:0] buf_d [BUF_DEPTH];
    logic [4:0] cnt_q, cnt_d, body_len;
    logic [7:0] sum_rx, rx_addr;
    logic ck_en, ck_ok, addr_ok, hex_ok, is_all, is_one, is_cfg, is_rdc, is_cal, cmd_ok;
    logic [4:0] h1, h2, hc1, hc2, dig;
    logic [4:0] hv [BUF_DEPTH];
    cfg_type new_cfg;
    always_comb begin
        ck_en = cfg_q.format_checksum_byte[`FMT_CKSUM_BIT];
        body_len = ck_en ? 5'(cnt_q - 5'd2) : cnt_q;
        sum_rx = 8'h00;
        for (int i = 0; i < BUF_DEPTH; i++) begin
            if (5'(i) < body_len) begin
                sum_rx = 8'(sum_rx + buf_q[i]);
            end
        end
        hc1 = hexv(buf_q[4'(cnt_q - 5'd2)]);
        hc2 = hexv(buf_q[4'(cnt_q - 5'd1)]);
        // command checksum must match the byte sum of everything before it [R17] [R7]
        ck_ok = !ck_en || (cnt_q >= 5'd5 && hc1[4] && hc2[4] && {hc1[3:0], hc2[3:0]} == sum_rx);
        h1 = hexv(buf_q[1]);
        h2 = hexv(buf_q[2]);
        rx_addr = {h1[3:0], h2[3:0]};
        // full 00..ff address match, no broadcast [R15] [R3]
        addr_ok = ck_ok && body_len >= 5'd3 && h1[4] && h2[4] && rx_addr == cfg_q.module_address;
        hex_ok = 1'b1;
        for (int i = 0; i < BUF_DEPTH; i++) begin
            hv[i] = hexv(buf_q[i]);
        end
        for (int i = 3; i < 11; i++) begin
            hex_ok = hex_ok & hv[i][4];
        end
        new_cfg.module_address = {hv[3][3:0], hv[4][3:0]};
        new_cfg.input_type_code = {hv[5][3:0], hv[6][3:0]};
        new_cfg.baud_code = {hv[7][3:0], hv[8][3:0]};
        new_cfg.format_checksum_byte = {hv[9][3:0], hv[10][3:0]};
        dig = (buf_q[3] >= `CHR_ZERO && buf_q[3] <= `CHR_SEVEN) ? {1'b1, buf_q[3][3:0]} : 5'h00;
        if (body_len == 5'd5) begin
            dig = (buf_q[4] >= `CHR_ZERO && buf_q[4] <= `CHR_SEVEN) ? {1'b1, buf_q[4][3:0]} : 5'h00;
        end
        is_all = buf_q[0] == `CHR_HASH && body_len == 5'd3; // [R1]
        is_one = buf_q[0] == `CHR_HASH && body_len == 5'd4 && dig[4]; // [R5]
        is_cfg = buf_q[0] == `CHR_PERCENT && body_len == 5'd11 && hex_ok; // [R9]
        is_rdc = buf_q[0] == `CHR_DOLLAR && body_len == 5'd4 && buf_q[3] == `CHR_RDCFG; // [R13]
        is_cal = buf_q[0] == `CHR_DOLLAR && body_len == 5'd5 && buf_q[3] == `CHR_CALIB
            && dig[4]; // [R14]
        cmd_ok = addr_ok && (is_all || is_one || is_cfg || is_rdc || is_cal); // [R3]
    end

    // ***************************************
    // receive, execute and reply sequencer
    // ***************************************
    logic [7:0] rep_q [REP_DEPTH];
    logic [7:0] rep_d [REP_DEPTH];
    logic [5:0] rep_len_q, rep_len_d, idx_q, idx_d;
    logic [7:0] sum_q, sum_d, tx_data_q, tx_data_d;
    logic tx_valid_q, tx_valid_d, ovf_q, ovf_d, dflt_q, dflt_d, nv_q, nv_d, cal_q, cal_d;
    logic [1:0] start_q, start_d;
    logic [2:0] cal_ch_q, cal_ch_d;
    logic [15:0] bps_q, bps_d;
    logic tx_free;
    always_comb begin
        int p;
        p = 0;
        state_d = state_q;
        cfg_d = cfg_q;
        buf_d = buf_q;
        cnt_d = cnt_q;
        rep_d = rep_q;
        rep_len_d = rep_len_q;
        idx_d = idx_q;
        sum_d = sum_q;
        ovf_d = ovf_q;
        dflt_d = dflt_q;
        start_d = start_q;
        cal_ch_d = cal_ch_q;
        nv_d = 1'b0;
        cal_d = 1'b0;
        tx_data_d = tx_data_q;
        tx_free = !tx_valid_q || TX_READY;
        tx_valid_d = tx_valid_q && !TX_READY;
        case (state_q)
            ST_RECV: begin
                if (start_q != `STRAP_SETTLE) begin
                    start_d = 2'(start_q + 2'h1);
                    if (2'(start_q + 2'h1) == `STRAP_SETTLE) begin
                        // strap caught once, after the synchroniser has settled [R19]
                        dflt_d = !sync_q[1];
                        cfg_d = sync_q[1]
                            ? cfg_type'({`FACTORY_ADDR, `FACTORY_TYPE, `FACTORY_BAUD, `FACTORY_FMT})
                            : cfg_type'({`DEFAULT_ADDR, `FACTORY_TYPE, `FACTORY_BAUD, `FACTORY_FMT});
                    end
                end else if (RX_VALID) begin
                    if (RX_DATA == `CHR_CR) begin
                        cnt_d = ovf_q ? 5'd0 : cnt_q; // [R20]
                        ovf_d = 1'b0;
                        state_d = ovf_q ? ST_RECV : ST_EXEC; // [R21]
                    end else if (cnt_q == 5'(BUF_DEPTH)) begin
                        ovf_d = 1'b1; // [R20]
                    end else begin
                        buf_d[cnt_q[3:0]] = RX_DATA; // [R20]
                        cnt_d = 5'(cnt_q + 5'd1);
                    end
                end
            end
            ST_EXEC: begin
                idx_d = 6'd0;
                sum_d = 8'h00;
                cnt_d = 5'd0;
                rep_d[0] = `CHR_BANG; // [R16]
                rep_d[1] = hexc(cfg_q.module_address[7:4]);
                rep_d[2] = hexc(cfg_q.module_address[3:0]);
                p = 3;
                if (is_all) begin
                    rep_d[0] = `CHR_GT; // [R1]
                    p = 1;
                    for (int c = 0; c < 8; c++) begin
                        for (int j = 0; j < 5; j++) begin
                            if (3'(j) < ch_len) begin
                                rep_d[p] = CH_ENABLE[c] ? ch_txt[c][39-8*j -: 8] : `CHR_SPACE; // [R2]
                                p = p + 1;
                            end
                        end
                    end
                end else if (is_one && CH_ENABLE[dig[2:0]]) begin
                    rep_d[0] = `CHR_GT; // [R5]
                    p = 1;
                    for (int j = 0; j < 5; j++) begin
                        if (3'(j) < ch_len) begin
                            rep_d[p] = ch_txt[dig[2:0]][39-8*j -: 8];
                            p = p + 1;
                        end
                    end
                end else if (cmd_ok && is_cfg && dflt_q && rx_addr == `DEFAULT_ADDR
                             && new_cfg.baud_code >= `BAUD_MIN
                             && new_cfg.baud_code <= `BAUD_MAX) begin
                    cfg_d = new_cfg; // [R9] [R11]
                    nv_d = 1'b1; // [R9]
                    rep_d[1] = hexc(new_cfg.module_address[7:4]); // [R12]
                    rep_d[2] = hexc(new_cfg.module_address[3:0]);
                end else if (is_rdc) begin
                    rep_d[3] = hexc(cfg_q.input_type_code[7:4]); // [R13]
                    rep_d[4] = hexc(cfg_q.input_type_code[3:0]);
                    rep_d[5] = hexc(cfg_q.baud_code[7:4]);
                    rep_d[6] = hexc(cfg_q.baud_code[3:0]);
                    rep_d[7] = hexc(cfg_q.format_checksum_byte[7:4]);
                    rep_d[8] = hexc(cfg_q.format_checksum_byte[3:0]);
                    p = 9;
                end else if (is_cal && cmd_ok) begin
                    cal_d = 1'b1; // [R14]
                    cal_ch_d = dig[2:0];
                end else begin
                    rep_d[0] = `CHR_QUERY; // [R4] [R5] [R11]
                end
                rep_len_d = 6'(p);
                state_d = cmd_ok ? ST_SEND : ST_RECV; // [R3]
            end
            ST_SEND: begin
                if (tx_free) begin
                    if (idx_q < rep_len_q) begin
                        tx_data_d = rep_q[idx_q];
                        tx_valid_d = 1'b1;
                        sum_d = 8'(sum_q + rep_q[idx_q]);
                        idx_d = 6'(idx_q + 6'd1);
                    end else begin
                        // checksum state follows the setting in force after the command [R7]
                        state_d = cfg_q.format_checksum_byte[`FMT_CKSUM_BIT] ? ST_CK_HI : ST_CR;
                    end
                end
            end
            ST_CK_HI: begin
                if (tx_free) begin
                    tx_data_d = hexc(sum_q[7:4]); // [R17]
                    tx_valid_d = 1'b1;
                    state_d = ST_CK_LO;
                end
            end
            ST_CK_LO: begin
                if (tx_free) begin
                    tx_data_d = hexc(sum_q[3:0]); // [R17]
                    tx_valid_d = 1'b1;
                    state_d = ST_CR;
                end
            end
            ST_CR: begin
                if (tx_free) begin
                    tx_data_d = `CHR_CR; // [R1]
                    tx_valid_d = 1'b1;
                    state_d = ST_RECV;
                end
            end
            default: begin
                state_d = ST_RECV;
            end
        endcase
        case (cfg_d.baud_code)
            8'h01: bps_d = `BPS_300; // [R10]
            8'h02: bps_d = `BPS_600;
            8'h03: bps_d = `BPS_1200;
            8'h04: bps_d = `BPS_2400;
            8'h05: bps_d = `BPS_4800;
            8'h07: bps_d = `BPS_19200;
            8'h08: bps_d = `BPS_38400;
            default: bps_d = `BPS_9600;
        endcase
    end

    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            state_q <= ST_RECV;
            cfg_q <= {`FACTORY_ADDR, `FACTORY_TYPE, `FACTORY_BAUD, `FACTORY_FMT};
            buf_q <= '{default: 8'h00};
            rep_q <= '{default: 8'h00};
            cnt_q <= 5'd0;
            rep_len_q <= 6'd0;
            idx_q <= 6'd0;
            sum_q <= 8'h00;
            ovf_q <= 1'b0;
            dflt_q <= 1'b0;
            start_q <= 2'h0;
            cal_ch_q <= 3'h0;
            nv_q <= 1'b0;
            cal_q <= 1'b0;
            tx_data_q <= 8'h00;
            tx_valid_q <= 1'b0;
            bps_q <= `BPS_9600;
        end else begin
            state_q <= state_d;
            cfg_q <= cfg_d;
            buf_q <= buf_d;
            rep_q <= rep_d;
            cnt_q <= cnt_d;
            rep_len_q <= rep_len_d;
            idx_q <= idx_d;
            sum_q <= sum_d;
            ovf_q <= ovf_d;
            dflt_q <= dflt_d;
            start_q <= start_d;
            cal_ch_q <= cal_ch_d;
            nv_q <= nv_d;
            cal_q <= cal_d;
            tx_data_q <= tx_data_d;
            tx_valid_q <= tx_valid_d;
            bps_q <= bps_d;
        end
    end

    assign TX_DATA = tx_data_q;
    assign TX_VALID = tx_valid_q;
    assign FORMAT_SEL = cfg_q.format_checksum_byte[`FMT_SEL_MSB:0];
    assign BAUD_BPS = bps_q;
    assign DEFAULT_STATE = dflt_q;
    assign NV_WRITE = nv_q;
    assign NV_DATA = cfg_q;
    assign CAL_START = cal_q;
    assign CAL_CHANNEL = cal_ch_q;

    // ***************************************
    // assertions
    // ***************************************
    default clocking @(posedge MCLK); endclocking
    default disable iff (!ARST_N);
    silent_on_error_a: assert property (state_q == ST_EXEC && !cmd_ok |=> state_q == ST_RECV [*2]) // [R3]
        else $error("reply started for a bad command");
    tx_after_exec_a: assert property ($rose(TX_VALID) |-> $past(state_q) != ST_RECV) // [R21]
        else $error("reply began while receiving");
    reply_ends_cr_a: assert property (state_q == ST_CR && tx_free |=> TX_VALID && TX_DATA == `CHR_CR) // [R1]
        else $error("reply not closed by carriage return");
    cfg_refused_a: assert property (state_q == ST_EXEC && cmd_ok && is_cfg // [R11]
        && (!dflt_q || rx_addr != `DEFAULT_ADDR)
        |=> rep_q[0] == `CHR_QUERY && !NV_WRITE) else $error("config accepted outside default");
    cfg_ack_a: assert property (state_q == ST_EXEC && cmd_ok && NV_WRITE == 1'b0 && nv_d // [R12]
        |=> NV_WRITE && rep_q[0] == `CHR_BANG && NV_DATA == $past(new_cfg))
        else $error("config acknowledge wrong");
    disabled_one_a: assert property (state_q == ST_EXEC && cmd_ok && is_one // [R5]
        && !CH_ENABLE[dig[2:0]] |=> rep_q[0] == `CHR_QUERY && rep_len_q == 6'd3)
        else $error("disabled channel not refused");
    overflow_drop_a: assert property (state_q == ST_RECV && ovf_q && RX_VALID // [R20]
        && RX_DATA == `CHR_CR |=> state_q == ST_RECV && cnt_q == 5'd0)
        else $error("overflowed command executed");
    checksum_gate_a: assert property (state_q == ST_CK_HI |-> cfg_q.format_checksum_byte[6]) // [R7]
        else $error("checksum sent while disabled");
    baud_map_a: assert property (cfg_q.baud_code == 8'h08 |-> BAUD_BPS == 16'd38400) // [R10]
        else $error("baud code mapping wrong");
    cal_pulse_a: assert property (CAL_START |=> !CAL_START ##0 state_q == ST_SEND) // [R14]
        else $error("calibration start not a single pulse");
    all_read_c: cover property (state_q == ST_EXEC && cmd_ok && is_all ##[1:200] state_q == ST_CR);
    cfg_write_c: cover property (NV_WRITE);
    cal_start_c: cover property (CAL_START);
    overflow_c: cover property (ovf_q && RX_VALID && RX_DATA == `CHR_CR);
endmodule
`default_nettype wire

/* hw/ascii_cmd_defs.svh */
// character codes, reset values, field positions and timing counts of the command parser
`ifndef ASCII_CMD_DEFS_SVH
`define ASCII_CMD_DEFS_SVH
`define CHR_CR 8'h0d
`define CHR_HASH 8'h23
`define CHR_DOLLAR 8'h24
`define CHR_PERCENT 8'h25
`define CHR_GT 8'h3e
`define CHR_BANG 8'h21
`define CHR_QUERY 8'h3f
`define CHR_SPACE 8'h20
`define CHR_PLUS 8'h2b
`define CHR_MINUS 8'h2d
`define CHR_ZERO 8'h30
`define CHR_SEVEN 8'h37
`define CHR_NINE 8'h39
`define CHR_UA 8'h41
`define CHR_UF 8'h46
`define CHR_CALIB 8'h31
`define CHR_RDCFG 8'h32
`define FACTORY_ADDR 8'h01
`define DEFAULT_ADDR 8'h00
`define FACTORY_TYPE 8'h00
`define FACTORY_BAUD 8'h06
`define FACTORY_FMT 8'h00
`define BAUD_MIN 8'h01
`define BAUD_MAX 8'h08
`define FMT_CKSUM_BIT 6
`define FMT_SEL_MSB 1
`define FMT_HEX 2'b10
`define STRAP_SETTLE 2'h3
`define BPS_300 16'd300
`define BPS_600 16'd600
`define BPS_1200 16'd1200
`define BPS_2400 16'd2400
`define BPS_4800 16'd4800
`define BPS_9600 16'd9600
`define BPS_19200 16'd19200
`define BPS_38400 16'd38400
`endif

/* hw/ascii_cmd_pkg.sv */
// types shared by the ascii command parser
package ascii_cmd_pkg;
    typedef enum logic [2:0] {ST_RECV, ST_EXEC, ST_SEND, ST_CK_HI, ST_CK_LO, ST_CR} state_type;
    typedef struct packed {
        logic [7:0] module_address;
        logic [7:0] input_type_code;
        logic [7:0] baud_code;
        logic [7:0] format_checksum_byte;
    } cfg_type;
endpackage

/* tb/host_model.sv */
// host side of the serial line: takes reply characters and gathers one reply line
`timescale 1ns/10ps
`default_nettype none
module host_model (
    input wire logic MCLK,
    input wire logic ARST_N,
    input wire logic SLOW,
    input wire logic [7:0] TX_DATA,
    input wire logic TX_VALID,
    output logic TX_READY
);
    // ********************************
    // reply capture
    // ********************************
    string line;
    bit done;
    initial TX_READY = 1'b0;
    // slow host takes every other cycle, so the parser must hold its character
    always @(negedge MCLK) begin
        TX_READY <= ARST_N && (SLOW ? !TX_READY : 1'b1);
    end
    // unknown characters are kept as '*' so they can never match a real reply
    always @(posedge MCLK) begin
        if (TX_VALID === 1'b1 && TX_READY) begin
            if (TX_DATA === 8'h0d) begin
                done = 1'b1;
            end else begin
                line = {line, string'((^TX_DATA === 1'bx) ? 8'h2a : TX_DATA)};
            end
        end
    end
endmodule
`default_nettype wire

/* tb/tb.sv */
// testbench of the ascii command parser: commands in, replies and side outputs checked
`timescale 1ns/10ps
`default_nettype none
module tb;
    import ascii_cmd_pkg::*;
    // ********************************
    // signals and instances
    // ********************************
    logic MCLK, ARST_N, CONFIG_N, RX_VALID, TX_VALID, TX_READY, slow;
    logic DEFAULT_STATE, NV_WRITE, CAL_START;
    logic [7:0] RX_DATA, TX_DATA, CH_ENABLE;
    logic [127:0] CH_VALUE;
    logic [1:0] FORMAT_SEL;
    logic [15:0] BAUD_BPS;
    logic [2:0] CAL_CHANNEL, cal_ch;
    cfg_type NV_DATA;
    int n_fail, total_checks, cycles, nv_n, cal_n, early;
    int bps [8] = '{300, 600, 1200, 2400, 4800, 9600, 19200, 38400};
    string e;

    ascii_cmd_parser i_ascii_cmd_parser (.MCLK(MCLK), .ARST_N(ARST_N), .CONFIG_N(CONFIG_N),
        .RX_DATA(RX_DATA), .RX_VALID(RX_VALID), .TX_DATA(TX_DATA), .TX_VALID(TX_VALID),
        .TX_READY(TX_READY), .CH_VALUE(CH_VALUE), .CH_ENABLE(CH_ENABLE),
        .FORMAT_SEL(FORMAT_SEL), .BAUD_BPS(BAUD_BPS), .DEFAULT_STATE(DEFAULT_STATE),
        .NV_WRITE(NV_WRITE), .NV_DATA(NV_DATA), .CAL_START(CAL_START),
        .CAL_CHANNEL(CAL_CHANNEL));
    host_model i_host_model (.MCLK(MCLK), .ARST_N(ARST_N), .SLOW(slow), .TX_DATA(TX_DATA),
        .TX_VALID(TX_VALID), .TX_READY(TX_READY));

    initial begin
        MCLK = 1'b0;
        forever #25 MCLK = ~MCLK;
    end
    // ********************************
    // watchers and hang limit
    // ********************************
    always @(posedge MCLK) begin
        cycles++;
        if (NV_WRITE === 1'b1) nv_n++;
        if (CAL_START === 1'b1) begin
            cal_n++;
            cal_ch = CAL_CHANNEL;
        end
        if (RX_VALID && TX_VALID !== 1'b0) early++;
        if (cycles == 20000) begin
            n_fail++;
            final_report;
        end
    end
    // ********************************
    // helpers
    // ********************************
    function automatic byte nib(logic [3:0] n);
        return (n < 10) ? 8'h30 + n : 8'h37 + n;
    endfunction
    function automatic string hx(logic [7:0] b);
        return $sformatf("%c%c", nib(b[7:4]), nib(b[3:0]));
    endfunction
    function automatic string val(int g, bit hexf);
        logic [15:0] v;
        byte s;
        v = CH_VALUE[16*g +: 16];
        if (hexf) return {hx(v[15:8]), hx(v[7:0])};
        s = v[15] ? 8'h2d : 8'h2b;
        if (v[15]) v = -v;
        return {string'(s), hx(v[15:8]), hx(v[7:0])};
    endfunction
    function automatic string ck(string s);
        logic [7:0] sum;
        sum = 8'h00;
        foreach (s[k]) sum += s[k];
        return hx(sum);
    endfunction
    task check(string seen, string exp);
        total_checks++;
        if (seen != exp) begin
            n_fail++;
            $display("unexpected at %0t: saw '%s' wanted '%s'", $time, seen, exp);
        end
    endtask
    task send(string s);
        foreach (s[k]) begin
            @(negedge MCLK);
            RX_DATA = s[k];
            RX_VALID = 1'b1;
        end
        @(negedge MCLK);
        RX_VALID = 1'b0;
    endtask
    // no reply is seen as an empty line once the wait runs out
    task cmd(string c, string exp, bit ckc = 0, bit ckr = 0);
        int k;
        i_host_model.line = "";
        i_host_model.done = 0;
        if (ckc) c = {c, ck(c)};
        send({c, "\r"});
        for (k = 0; k < 300 && !i_host_model.done; k++) @(negedge MCLK);
        if (ckr && exp != "") exp = {exp, ck(exp)};
        check(i_host_model.line, exp);
        repeat (2) @(negedge MCLK);
    endtask
    task rst(logic cfg);
        ARST_N = 1'b0;
        CONFIG_N = cfg;
        repeat (12) @(negedge MCLK);
        ARST_N = 1'b1;
        repeat (4) @(negedge MCLK);
    endtask
    task final_report;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // ********************************
    // tests
    // ********************************
    initial begin
        RX_DATA = 8'h00;
        RX_VALID = 1'b0;
        slow = 1'b0;
        CH_ENABLE = 8'hfd;
        for (int g = 0; g < 8; g++) CH_VALUE[16*g +: 16] = (g == 7) ? 16'hff38 : 16'h0112 * g;
        rst(1'b0);
        check($sformatf("%b %0d %b", DEFAULT_STATE, BAUD_BPS, FORMAT_SEL), "1 9600 00");
        cmd("$002", "!00000600");
        e = ">";
        for (int g = 0; g < 8; g++) e = {e, CH_ENABLE[g] ? val(g, 0) : "     "};
        cmd("#00", e);
        slow = 1'b1;
        cmd("#007", {">", val(7, 0)});
        cmd("#001", "?00");
        $display("test reads done");
        cmd("#05", "");
        cmd("#0G", "");
        cmd("%0511000600", "");
        cmd("#00000000000000000000", "");
        cmd("$0013", "!00");
        check($sformatf("%0d %0d", cal_n, cal_ch), "1 3");
        cmd("%0000000900", "?00");
        slow = 1'b0;
        $display("test errors done");
        for (int i = 1; i <= 8; i++) begin
            cmd({"%000000", hx(i[7:0]), hx(8'(i % 3))}, "!00");
            check($sformatf("%0d %0d %h %0d", BAUD_BPS, FORMAT_SEL, NV_DATA, nv_n),
                $sformatf("%0d %0d %h %0d", bps[i-1], i % 3,
                {16'h0000, i[7:0], 6'h00, 2'(i % 3)}, i));
        end
        cmd("#005", {">", val(5, 1)});
        $display("test config done");
        cmd("%00FF000640", "!FF", 0, 1);
        cmd("$FF2", "!FF000640", 1, 1);
        cmd("$FF200", "", 0, 1);
        cmd("%FF01000640", "?FF", 1, 1);
        $display("test checksum done");
        rst(1'b1);
        check($sformatf("%b", DEFAULT_STATE), "0");
        cmd("$012", "!01000600");
        cmd("%0102000600", "?01");
        check($sformatf("%0d", early), "0");
        $display("test strap done");
        final_report;
    end
endmodule
`default_nettype wire
